// ===== test/timer_rtc_interrupt_halt_tb.sv
// Bench for the timer, tick, interrupt and halt controller.
// Assumes the sequencer stand-in and a 125 MHz mclk.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module timer_rtc_interrupt_halt_tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        xtal = 1'b0;
  logic        xtal_run = 1'b0;
  logic [3:0]  wake_s = 4'hf;
  logic        carry_wr = 1'b0;
  logic        carry_wr_val = 1'b0;
  logic [11:0] seq_pc, pc_load_addr, pc_at, ret;
  logic        seq_carry, pc_load, carry_load, carry_load_val;
  logic        sys_clock_stop, display_enable, single_play_mode;
  logic [3:0]  general_output_port;
  logic [1:0]  buzzer_output;
  logic [11:0] vq[$];
  logic [31:0] q;
  logic [7:0]  c1;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          n_cl = 0;
  int          cl, i;

  // Clock, and a gated crystal well below mclk
  always #4 mclk = ~mclk;
  always
  begin
    repeat (3) @(posedge mclk);
    if (xtal_run)
      xtal <= ~xtal;
  end

  // Log every pc load and carry load mid-cycle, where they are settled
  always @(negedge mclk)
  begin
    if (pc_load === 1'b1)
      vq.push_back(pc_load_addr);
    if (carry_load === 1'b1)
      n_cl++;
  end

  trh_ctrl dut_u (
    .mclk                (mclk),
    .srst                (srst),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (4'hf),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .timer_ext_clock_pin (1'b0),
    .xtal_clk_pin        (xtal),
    .wake_input_port_m   (3'h7),
    .wake_input_port_s   (wake_s),
    .buzz_tone           (1'b0),
    .seq_pc              (seq_pc),
    .seq_carry           (seq_carry),
    .pc_load             (pc_load),
    .pc_load_addr        (pc_load_addr),
    .carry_load          (carry_load),
    .carry_load_val      (carry_load_val),
    .sys_clock_stop      (sys_clock_stop),
    .general_output_port (general_output_port),
    .display_enable      (display_enable),
    .single_play_mode    (single_play_mode),
    .buzzer_output       (buzzer_output)
  );

  trh_seq_model seq_u (
    .mclk           (mclk),
    .srst           (srst),
    .pc_load        (pc_load),
    .pc_load_addr   (pc_load_addr),
    .carry_load     (carry_load),
    .carry_load_val (carry_load_val),
    .sys_clock_stop (sys_clock_stop),
    .carry_wr       (carry_wr),
    .carry_wr_val   (carry_wr_val),
    .seq_pc         (seq_pc),
    .seq_carry      (seq_carry)
  );

  task automatic conclude();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("ERROR wait ran out");
    conclude();
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      give_up();
    q = avs_readdata;
    pc_at = seq_pc;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic cmd(input int b);
    bus(1'b1, trh_pkg::OFS_CMD, 32'h1 << b);
  endtask

  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask

  // Wait for the next pc load; compare it when asked
  task automatic vec(input logic [11:0] ex, input bit cmp);
    int n;
    for (n = 0; n < 3000 && vq.size() == 0; n++)
      @(posedge mclk);
    if (vq.size() == 0)
      give_up();
    if (cmp)
      `CHK("vector", ex, vq[0])
    void'(vq.pop_front());
  endtask

  task automatic wait_wake();
    int n;
    for (n = 0; n < 3000 && sys_clock_stop !== 1'b0; n++)
      @(posedge mclk);
    if (sys_clock_stop !== 1'b0)
      give_up();
  endtask

  // Load near the top, run past the wrap, stop before any read
  task automatic make_ovf();
    bus(1'b1, trh_pkg::OFS_COUNT, 32'hfe);
    cmd(0);
    repeat (20) @(posedge mclk);
    cmd(1);
  endtask

  task automatic set_cy(input logic v);
    carry_wr_val <= v;
    carry_wr     <= 1'b1;
    @(posedge mclk);
    carry_wr     <= 1'b0;
  endtask

  initial
  begin
    // reset pulse, length scaled down for simulation
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) @(posedge mclk);
    vec(12'h000, 1'b1);
    vq.delete();
    `CHK("buzzer", 2'h3, buzzer_output)
    `CHK("port", 4'hf, general_output_port)
    `CHK("display", 1'b0, display_enable)
    `CHK("single", 1'b1, single_play_mode)
    rd("misc", trh_pkg::OFS_MISC, 32'h2f);
    rd("status", trh_pkg::OFS_STATUS, 32'h0);
    rd("count", trh_pkg::OFS_COUNT, 32'h0);
    rd("unmapped", 4'h2, 32'h0);
    rd("cmd", trh_pkg::OFS_CMD, 32'h0);
    bus(1'b1, trh_pkg::OFS_COUNT, 32'ha5);
    rd("load", trh_pkg::OFS_COUNT, 32'ha5);
    make_ovf();
    rd("ovf", trh_pkg::OFS_STATUS, 32'h1);
    bus(1'b0, trh_pkg::OFS_COUNT, 32'h0);
    c1 = q[7:0];
    `CHK("wrapped", 1'b1, c1 > 8'h00 && c1 < 8'h30)
    rd("stopped", trh_pkg::OFS_COUNT, {24'h0, c1});
    `CHK("held", 0, vq.size())
    cmd(7);
    rd("jump", trh_pkg::OFS_STATUS, 32'h100);
    cmd(7);
    rd("jump2", trh_pkg::OFS_STATUS, 32'h0);
    // wrap lands in the cycle the jump command clears the flag
    bus(1'b1, trh_pkg::OFS_COUNT, 32'hfd);
    cmd(0);
    cmd(7);
    cmd(1);
    rd("set_wins", trh_pkg::OFS_STATUS, 32'h1);
    make_ovf();
    set_cy(1'b1);
    cmd(2);
    vec(trh_pkg::VEC_TIMER, 1'b1);
    rd("isr", trh_pkg::OFS_STATUS, 32'h9c);
    set_cy(1'b0);
    cmd(6);
    vec(12'h000, 1'b0);
    // Let the sequencer take the restored carry
    @(posedge mclk);
    `CHK("carry", 1'b1, seq_carry)
    cmd(4);
    ret = pc_at;
    make_ovf();
    `CHK("in_call", 0, vq.size())
    cl = n_cl;
    cmd(5);
    vec(ret, 1'b1);
    vec(trh_pkg::VEC_TIMER, 1'b1);
    `CHK("no_carry", cl, n_cl)
    cmd(6);
    vec(ret, 1'b1);
    cmd(3);
    make_ovf();
    xtal_run <= 1'b1;
    q = 32'h0;
    for (i = 0; i < 400 && q[1] !== 1'b1; i++)
      bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    if (q[1] !== 1'b1)
      give_up();
    xtal_run <= 1'b0;
    cmd(2);
    vec(trh_pkg::VEC_TICK, 1'b1);
    rd("tick_clr", trh_pkg::OFS_STATUS, 32'h9d);
    cmd(6);
    vec(12'h000, 1'b0);
    vec(trh_pkg::VEC_TIMER, 1'b1);
    cmd(6);
    vec(12'h000, 1'b0);
    cmd(3);
    cmd(8);
    `CHK("halted", 1'b1, sys_clock_stop)
    `CHK("buzz_halt", 2'h3, buzzer_output)
    wake_s <= 4'he;
    wait_wake();
    wake_s <= 4'hf;
    cmd(8);
    xtal_run <= 1'b1;
    wait_wake();
    xtal_run <= 1'b0;
    bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    `CHK("tick_held", 3'h2, q[2:0])
    `CHK("no_entry", 0, vq.size())
    cmd(2);
    vec(trh_pkg::VEC_TICK, 1'b1);
    cmd(6);
    vec(12'h000, 1'b0);
    cmd(8);
    xtal_run <= 1'b1;
    vec(trh_pkg::VEC_TICK, 1'b1);
    xtal_run <= 1'b0;
    `CHK("woken", 1'b0, sys_clock_stop)
    cmd(6);
    vec(12'h000, 1'b0);
    cmd(8);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("reset_run", 1'b0, sys_clock_stop)
    vec(trh_pkg::VEC_RESET, 1'b1);
    bus(1'b0, trh_pkg::OFS_STATUS, 32'h0);
    `CHK("reset_stat", 6'h0, q[5:0])
    bus(1'b1, trh_pkg::OFS_MISC, 32'h5a);
    `CHK("port_wr", 4'ha, general_output_port)
    `CHK("disp_wr", 1'b1, display_enable)
    `CHK("single_wr", 1'b0, single_play_mode)
    `CHK("buzz_on", 2'h2, buzzer_output)
    conclude();
  end
endmodule

// ===== test/trh_seq_model.sv
// Sequencer stand-in: follows pc and carry loads, steps while clocked.
// Assumes the controller pulses its load outputs on mclk.
`timescale 1ns/1ps
module trh_seq_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_addr,
  input  wire logic        carry_load,
  input  wire logic        carry_load_val,
  input  wire logic        sys_clock_stop,
  input  wire logic        carry_wr,
  input  wire logic        carry_wr_val,
  output logic      [11:0] seq_pc,
  output logic             seq_carry
);
  logic [11:0] pc_q;
  logic [11:0] pc_d;
  logic        cy_q;
  logic        cy_d;

  // Next address and carry
  always_comb
  begin
    pc_d = pc_q;
    cy_d = cy_q;
    if (pc_load)
      pc_d = pc_load_addr;
    else if (!sys_clock_stop)
      pc_d = pc_q + 12'h001;
    if (carry_load)
      cy_d = carry_load_val;
    else if (carry_wr)
      cy_d = carry_wr_val;
  end

  // State registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pc_q <= 12'h000;
      cy_q <= 1'b0;
    end
    else
    begin
      pc_q <= pc_d;
      cy_q <= cy_d;
    end
  end

  assign seq_pc    = pc_q;
  assign seq_carry = cy_q;
endmodule

// ===== verilog/trh_ctrl.sv
// Timer, real-time tick, interrupt arbitration, stack and halt control.
// Assumes the instruction sequencer issues commands by bus writes, follows
// pc_load / carry_load pulses, and stops on sys_clock_stop.
`timescale 1ns/1ps
module trh_ctrl #(
  parameter bit         TIMER_EXT = 1'b0,  // Count the external pin
  parameter int         TIMER_N   = 0,     // Internal divide, 0..13
  parameter int         RTC_N     = 0,     // Tick divide, 0..7
  parameter logic [6:0] WAKE_MASK = 7'h7f  // Pins allowed to wake
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timer_ext_clock_pin,
  input  wire logic        xtal_clk_pin,
  input  wire logic [2:0]  wake_input_port_m,
  input  wire logic [3:0]  wake_input_port_s,
  input  wire logic        buzz_tone,
  input  wire logic [11:0] seq_pc,
  input  wire logic        seq_carry,
  output logic             pc_load,
  output logic      [11:0] pc_load_addr,
  output logic             carry_load,
  output logic             carry_load_val,
  output logic             sys_clock_stop,
  output logic      [3:0]  general_output_port,
  output logic             display_enable,
  output logic             single_play_mode,
  output logic      [1:0]  buzzer_output
);

  typedef enum logic {ST_RUN, ST_HALT} trh_state_t;

  localparam int TMR_DIV = 1 << TIMER_N;
  localparam int RTC_DIV = trh_pkg::XTAL_PER_TICK << RTC_N;

  logic       ext_rise, xtal_rise, int_step, rtc_tick;
  logic [6:0] wake_fall;

  trh_sync #(.W(1), .RST_VAL(1'b1)) u_sync_tmr (
    .mclk (mclk),
    .srst (srst),
    .pin  (timer_ext_clock_pin),
    .rise (ext_rise),
    .fall ()
  );

  // Crystal clock sampled as an ordinary input
  trh_sync #(.W(1), .RST_VAL(1'b0)) u_sync_xtal (
    .mclk (mclk),
    .srst (srst),
    .pin  (xtal_clk_pin),
    .rise (xtal_rise),
    .fall ()
  );

  // Wake pins, pulled high when idle
  trh_sync #(.W(7), .RST_VAL(7'h7f)) u_sync_wake (
    .mclk (mclk),
    .srst (srst),
    .pin  ({wake_input_port_m, wake_input_port_s}),
    .rise (),
    .fall (wake_fall)
  );

  trh_state_t state_q, state_d;

  // internal timer clock, stopped with the system clock
  trh_div #(.DIV(TMR_DIV)) u_div_tmr (
    .mclk  (mclk),
    .srst  (srst),
    .en    (state_q == ST_RUN),
    .pulse (int_step)
  );

  trh_div #(.DIV(RTC_DIV)) u_div_rtc (
    .mclk  (mclk),
    .srst  (srst),
    .en    (xtal_rise),
    .pulse (rtc_tick)
  );

  // ------------------------------------------------------------------
  // Bus slave: answer one cycle after the request, write at that edge
  // ------------------------------------------------------------------
  logic              wait_q, wait_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              commit, wr_count, wr_misc;
  trh_pkg::trh_cmd_t  cmd;
  trh_pkg::trh_stat_t stat;
  trh_pkg::trh_misc_t misc_q, misc_d;
  logic [7:0]        count_q, count_d;

  // Write decode, acting only when waitrequest is seen low
  always_comb
  begin
    commit   = avs_write && !wait_q;
    wr_count = commit && avs_address == trh_pkg::OFS_COUNT
               && avs_byteenable[0];
    wr_misc  = commit && avs_address == trh_pkg::OFS_MISC
               && avs_byteenable[0];
    if (commit && avs_address == trh_pkg::OFS_CMD
        && avs_byteenable[1:0] == 2'h3)
      cmd = trh_pkg::trh_cmd_t'(avs_writedata[8:0]);
    else
      cmd = '0;
  end

  // Read mux and waitrequest
  always_comb
  begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((avs_read || avs_write) && wait_q)
    begin
      wait_d = 1'b0;
      case (avs_address)
        trh_pkg::OFS_COUNT:  rdata_d = {24'h000000, count_q};
        trh_pkg::OFS_STATUS: rdata_d = {23'h000000, stat};
        trh_pkg::OFS_MISC:   rdata_d = {25'h0000000, misc_q};
        default:             rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // ------------------------------------------------------------------
  // Core state: timer, latches, stack, halt and sequencer outputs
  // ------------------------------------------------------------------
  logic        run_q, run_d, ovf_q, ovf_d, tick_q, tick_d;
  logic        ie_q, ie_d, call_q, call_d, isr_q, isr_d;
  logic        jtk_q, jtk_d, stk_cf_q, stk_cf_d;
  logic [11:0] stk_pc_q, stk_pc_d, addr_q, addr_d;
  logic        pcl_q, pcl_d, cl_q, cl_d, cv_q, cv_d, stop_q, stop_d;
  logic [1:0]  buzz_q, buzz_d;
  logic        timer_step, wrap, can_take, take_tick, take_ovf;
  logic [11:0] push_pc;
  logic        push_cf;

  always_comb
  begin
    stat = '{jump_taken: jtk_q, carry_saved: stk_cf_q,
             halted: state_q == ST_HALT, timer_running: run_q,
             isr_active: isr_q, in_call: call_q, int_enabled: ie_q,
             tick_pending: tick_q, overflow_flag: ovf_q};
  end

  // Next values of the core state
  always_comb
  begin
    // step on the selected clock edge
    timer_step = run_q && state_q == ST_RUN
                 && (TIMER_EXT ? ext_rise : int_step);
    wrap       = timer_step && count_q == trh_pkg::COUNT_MAX;
    // acknowledge held inside a call, while disabled, or on a command
    can_take   = ie_q && !call_q && state_q == ST_RUN && cmd == '0;
    take_tick  = can_take && tick_q;
    take_ovf   = can_take && !tick_q && ovf_q;
    // a load sent last cycle is what the sequencer now holds
    push_pc    = pcl_q ? addr_q : seq_pc;
    push_cf    = cl_q ? cv_q : seq_carry;
    count_d  = count_q;
    run_d    = run_q;
    ovf_d    = ovf_q;
    tick_d   = tick_q;
    ie_d     = ie_q;
    call_d   = call_q;
    isr_d    = isr_q;
    jtk_d    = jtk_q;
    stk_pc_d = stk_pc_q;
    stk_cf_d = stk_cf_q;
    state_d  = state_q;
    misc_d   = misc_q;
    addr_d   = addr_q;
    pcl_d    = 1'b0;
    cl_d     = 1'b0;
    cv_d     = cv_q;
    // load first, then counting resumes from that value
    if (wr_count)
      count_d = avs_writedata[7:0];
    // up count with natural wrap to 00
    else if (timer_step)
      count_d = count_q + 8'h01;
    if (cmd.timer_stop)
      run_d = 1'b0;
    else if (cmd.timer_run)
      run_d = 1'b1;
    if (cmd.int_disable)
      ie_d = 1'b0;
    else if (cmd.int_enable)
      ie_d = 1'b1;
    if (wr_misc)
      misc_d = trh_pkg::trh_misc_t'(avs_writedata[6:0]);
    // test and clear the overflow flag
    if (cmd.jump_ovf)
    begin
      jtk_d = ovf_q;
      ovf_d = 1'b0;
    end
    // plain call saves the address only
    if (cmd.sub_call)
    begin
      call_d   = 1'b1;
      stk_pc_d = push_pc;
    end
    // both returns reload the address; only one restores carry
    if (cmd.sub_return || cmd.int_return)
    begin
      call_d = 1'b0;
      isr_d  = 1'b0;
      pcl_d  = 1'b1;
      addr_d = stk_pc_q;
      cl_d   = cmd.int_return;
      cv_d   = cmd.int_return ? stk_cf_q : cv_q;
    end
    // tick entry, address and carry saved
    if (take_tick)
    begin
      tick_d   = 1'b0;
      pcl_d    = 1'b1;
      addr_d   = trh_pkg::VEC_TICK;
      call_d   = 1'b1;
      isr_d    = 1'b1;
      stk_pc_d = push_pc;
      stk_cf_d = push_cf;
    end
    else if (take_ovf)
    begin
      ovf_d    = 1'b0;
      pcl_d    = 1'b1;
      addr_d   = trh_pkg::VEC_TIMER;
      call_d   = 1'b1;
      isr_d    = 1'b1;
      stk_pc_d = push_pc;
      stk_cf_d = push_cf;
    end
    // new events set after any clear, so set wins
    if (wrap)
      ovf_d = 1'b1;
    if (rtc_tick)
      tick_d = 1'b1;
    case (state_q)
      ST_RUN:
        if (cmd.halt)
          state_d = ST_HALT;
      ST_HALT:
        if (rtc_tick || |(wake_fall & WAKE_MASK))
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
    stop_d = state_d == ST_HALT;
    buzz_d = (stop_d || !misc_d.sound_on) ? trh_pkg::BUZZ_IDLE
             : {~buzz_tone, buzz_tone};
  end

  // reset values, reset restarts at 000
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      count_q  <= trh_pkg::COUNT_RST;
      run_q    <= 1'b0;
      ovf_q    <= 1'b0;
      tick_q   <= 1'b0;
      ie_q     <= 1'b0;
      call_q   <= 1'b0;
      isr_q    <= 1'b0;
      jtk_q    <= 1'b0;
      stk_pc_q <= trh_pkg::VEC_RESET;
      stk_cf_q <= 1'b0;
      state_q  <= ST_RUN;
      misc_q   <= trh_pkg::MISC_RST;
      addr_q   <= trh_pkg::VEC_RESET;
      pcl_q    <= 1'b1;
      cl_q     <= 1'b1;
      cv_q     <= 1'b0;
      stop_q   <= 1'b0;
      buzz_q   <= trh_pkg::BUZZ_IDLE;
    end
    else
    begin
      count_q  <= count_d;
      run_q    <= run_d;
      ovf_q    <= ovf_d;
      tick_q   <= tick_d;
      ie_q     <= ie_d;
      call_q   <= call_d;
      isr_q    <= isr_d;
      jtk_q    <= jtk_d;
      stk_pc_q <= stk_pc_d;
      stk_cf_q <= stk_cf_d;
      state_q  <= state_d;
      misc_q   <= misc_d;
      addr_q   <= addr_d;
      pcl_q    <= pcl_d;
      cl_q     <= cl_d;
      cv_q     <= cv_d;
      stop_q   <= stop_d;
      buzz_q   <= buzz_d;
    end
  end

  // Outputs straight from flops
  assign pc_load             = pcl_q;
  assign pc_load_addr        = addr_q;
  assign carry_load          = cl_q;
  assign carry_load_val      = cv_q;
  assign sys_clock_stop      = stop_q;
  assign general_output_port = misc_q.port;
  assign display_enable      = misc_q.display_enable;
  assign single_play_mode    = misc_q.single_play_mode;
  assign buzzer_output       = buzz_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_tick_take;
    can_take && tick_q;
  endsequence

  sequence s_tick_entry;
    pcl_q && addr_q == trh_pkg::VEC_TICK && isr_q;
  endsequence

  a_wrap_sets_flag: assert property (@(posedge mclk) disable iff (srst)
    wrap && !wr_count |=> ovf_q && count_q == 8'h00)
    else $error("wrap did not set overflow or clear count");

  a_tick_first: assert property (@(posedge mclk) disable iff (srst)
    s_tick_take |=> s_tick_entry)
    else $error("pending tick not entered first");

  a_ovf_vector: assert property (@(posedge mclk) disable iff (srst)
    take_ovf && !wrap |=> pcl_q && addr_q == 12'h004 && !ovf_q)
    else $error("overflow entry wrong");

  a_defer_entry: assert property (@(posedge mclk) disable iff (srst)
    (call_q || !ie_q) && !isr_q |=> !isr_q)
    else $error("interrupt taken while deferred");

  a_stop_holds: assert property (@(posedge mclk) disable iff (srst)
    !run_q && !wr_count |=> count_q == $past(count_q))
    else $error("stopped timer moved");

  a_di_off: assert property (@(posedge mclk) disable iff (srst)
    cmd.int_disable |=> !ie_q [*2] or (!ie_q ##1 ie_q))
    else $error("disable did not clear enable");

  a_interrupt_return_instr_carry: assert property (@(posedge mclk) disable iff (srst)
    cmd.int_return && !take_tick && !take_ovf
    |=> cl_q && cv_q == $past(stk_cf_q) && addr_q == $past(stk_pc_q))
    else $error("interrupt return lost carry");

  a_halt_buzz: assert property (@(posedge mclk) disable iff (srst)
    state_q == ST_HALT |-> buzz_q == 2'h3 && stop_q && !timer_step)
    else $error("halt outputs wrong");

  a_set_wins: assert property (@(posedge mclk) disable iff (srst)
    wrap && cmd.jump_ovf |=> ovf_q)
    else $error("overflow lost on clear");

  a_reset_image: assert property (@(posedge mclk)
    $fell(srst) |-> pcl_q && addr_q == 12'h000 && !run_q && !ovf_q
                    && general_output_port == 4'hf && buzz_q == 2'h3)
    else $error("reset image wrong");

endmodule

// ===== verilog/trh_div.sv
// Enable-driven divider: one pulse per DIV enabled cycles.
// Assumes en is a single-cycle or level enable on mclk.
`timescale 1ns/1ps
module trh_div #(
  parameter int DIV = 1
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic en,
  output logic      pulse
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          pulse_d;

  // Count enabled cycles and wrap at the last one
  always_comb
  begin
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (en)
    begin
      if (cnt_q == LAST)
      begin
        cnt_d   = '0;
        pulse_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  // Register count and pulse
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pulse <= pulse_d;
    end
  end

endmodule

// ===== verilog/trh_pkg.sv
// Constants and carrier types for the timer, tick, interrupt and halt block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package trh_pkg;

  // Register byte offsets on the slave bus
  localparam logic [3:0]  OFS_COUNT  = 4'h0;
  localparam logic [3:0]  OFS_CMD    = 4'h4;
  localparam logic [3:0]  OFS_STATUS = 4'h8;
  localparam logic [3:0]  OFS_MISC   = 4'hc;

  // Program addresses handed to the sequencer
  localparam logic [11:0] VEC_RESET  = 12'h000;
  localparam logic [11:0] VEC_TIMER  = 12'h004;
  localparam logic [11:0] VEC_TICK   = 12'h008;

  // Timer reset and wrap values, output reset values
  localparam logic [7:0]  COUNT_RST  = 8'h00;
  localparam logic [7:0]  COUNT_MAX  = 8'hff;
  localparam logic [3:0]  PORT_RST   = 4'hf;
  localparam logic [1:0]  BUZZ_IDLE  = 2'h3;

  // Crystal edges per 256 Hz tick (32768 / 256)
  localparam int          XTAL_PER_TICK = 128;

  // Command register, one bit per sequencer command
  typedef struct packed {
    logic halt;
    logic jump_ovf;
    logic int_return;
    logic sub_return;
    logic sub_call;
    logic int_disable;
    logic int_enable;
    logic timer_stop;
    logic timer_run;
  } trh_cmd_t;

  // Status register image
  typedef struct packed {
    logic jump_taken;
    logic carry_saved;
    logic halted;
    logic timer_running;
    logic isr_active;
    logic in_call;
    logic int_enabled;
    logic tick_pending;
    logic overflow_flag;
  } trh_stat_t;

  // Port, display and sound control register
  typedef struct packed {
    logic       sound_on;
    logic       single_play_mode;
    logic       display_enable;
    logic [3:0] port;
  } trh_misc_t;

  localparam trh_misc_t MISC_RST = '{sound_on: 1'b0, single_play_mode: 1'b1,
                                     display_enable: 1'b0, port: PORT_RST};

endpackage

// ===== verilog/trh_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pins are asynchronous to mclk.
`timescale 1ns/1ps
module trh_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_q, s2_q, s3_q, stab_q, stab_d;

  // Level accepted only once stages two and three agree
  always_comb
  begin
    stab_d = (s2_q & s3_q) | (stab_q & (s2_q | s3_q));
  end

  // Shift chain, filtered level and edge pulses
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      stab_q <= RST_VAL;
      rise   <= '0;
      fall   <= '0;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= stab_d;
      rise   <= stab_d & ~stab_q;
      fall   <= ~stab_d & stab_q;
    end
  end

endmodule
